// *** hdl/hmv_debounce.sv ***
// Minimum-low-time qualifier for one active-low button input
`timescale 1ns/10ps
`default_nettype none
`include "hmv_defs.svh"

module hmv_debounce #(
	parameter int unsigned CYCLES = `HMV_DEBOUNCE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic button_n,
	output logic qualified
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	if (CYCLES < 2) begin : g_bad_cycles
		$error("hmv_debounce: CYCLES must be at least 2");
	end

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_qualified;

	always_comb begin
		next_cnt = cnt;
		next_qualified = qualified;
		if (button_n) begin
			next_cnt = '0;
			next_qualified = 1'b0;
		end else if (cnt == LAST) begin
			next_qualified = 1'b1;
		end else begin
			next_cnt = cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			qualified <= 1'b0;
		end else begin
			cnt <= next_cnt;
			qualified <= next_qualified;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_qual_after_hold: assert property ($rose(qualified)
		|-> $past(cnt) == LAST && !$past(button_n))
		else $error("button qualified before its hold time");
	chk_release_drops: assert property (button_n |=> !qualified)
		else $error("qualification kept after release");

endmodule // hmv_debounce

`default_nettype wire

// *** hdl/hmv_defs.svh ***
// Constants for the hardware master volume button block
`ifndef HMV_DEFS_SVH
`define HMV_DEFS_SVH

`define HMV_CLK_MHZ 250
`define HMV_DEBOUNCE_MS 25
`define HMV_DEBOUNCE_CYCLES (`HMV_DEBOUNCE_MS * `HMV_CLK_MHZ * 1000)
`define HMV_STEP_DB_TENTHS 15
`define HMV_RATE_DB_TENTHS_PER_S 15
`define HMV_STEP_MS (`HMV_STEP_DB_TENTHS * 1000 / `HMV_RATE_DB_TENTHS_PER_S)
`define HMV_STEP_CYCLES (`HMV_STEP_MS * `HMV_CLK_MHZ * 1000)
`define HMV_RANGE_DB_TENTHS 450
`define HMV_ATTN_MAX (`HMV_RANGE_DB_TENTHS / `HMV_STEP_DB_TENTHS)
`define HMV_IDX_LEVEL 10'h029
`define HMV_IDX_STATUS 10'h02a
`define HMV_LEVEL_RESET 16'h0000
`define HMV_ST_DOWN_BIT 0
`define HMV_ST_UP_BIT 1
`define HMV_ST_MODE_LSB 2
`define HMV_ST_MODE_MSB 5

`endif

// *** hdl/hmv_pkg.sv ***
// Types shared by the hardware master volume button block
`default_nettype none

package hmv_pkg;

	typedef struct packed {
		logic r_mute;
		logic [1:0] r_rsv;
		logic [4:0] r_attn;
		logic l_mute;
		logic [1:0] l_rsv;
		logic [4:0] l_attn;
	} hmv_level_t;

	typedef struct packed {
		logic down;
		logic up;
	} hmv_buttons_t;

	typedef enum logic [3:0] {
		HMV_IDLE = 4'b0001,
		HMV_DOWN = 4'b0010,
		HMV_UP = 4'b0100,
		HMV_MUTE = 4'b1000
	} hmv_mode_t;

endpackage

`default_nettype wire

// *** hdl/hmv_top.sv ***
// Hardware master volume buttons with APB register access
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "hmv_defs.svh"

module hmv_top
	import hmv_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = `HMV_DEBOUNCE_CYCLES,
	parameter int unsigned STEP_CYCLES = `HMV_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic volume_down_button_n,
	input wire logic volume_up_button_n,
	output logic [4:0] left_out_attn,
	output logic left_out_mute,
	output logic [4:0] right_out_attn,
	output logic right_out_mute
);

	localparam logic [4:0] ATTN_MAX = 5'(`HMV_ATTN_MAX);
	localparam int SW = $clog2(STEP_CYCLES + 1);
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

	// Both timers need at least two counts per period
	if (STEP_CYCLES < 2) begin : g_bad_step
		$error("hmv_top: STEP_CYCLES must be at least 2");
	end
	if (DEBOUNCE_CYCLES < 2) begin : g_bad_debounce
		$error("hmv_top: DEBOUNCE_CYCLES must be at least 2");
	end

	// Saturating one-step move of an attenuation code
	function automatic logic [4:0] hmv_step(input logic [4:0] attn, input logic louder);
		logic [4:0] res;
		res = attn;
		if (louder) begin
			if (attn != 5'h00) begin
				res = attn - 5'h01;
			end
		end else if (attn < ATTN_MAX) begin
			res = attn + 5'h01;
		end
		return res;
	endfunction

	// Limits a software-written code to the attenuation range
	function automatic logic [4:0] hmv_clamp(input logic [4:0] attn);
		logic [4:0] res;
		res = attn;
		if (attn > ATTN_MAX) begin
			res = ATTN_MAX;
		end
		return res;
	endfunction

	// Reset release through two flip-flops
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Button qualification
	wire hmv_buttons_t qual;

	hmv_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_deb_down (
		.clk(clk),
		.rst_n(rst_n),
		.button_n(volume_down_button_n),
		.qualified(qual.down)
	);

	hmv_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_deb_up (
		.clk(clk),
		.rst_n(rst_n),
		.button_n(volume_up_button_n),
		.qualified(qual.up)
	);

	// Button mode and step rate timer
	hmv_mode_t mode;
	hmv_mode_t next_mode;
	logic [SW-1:0] step_cnt;
	logic [SW-1:0] next_step_cnt;
	logic step;

	always_comb begin
		if (qual.down && qual.up) begin
			next_mode = HMV_MUTE;
		end else if (qual.down) begin
			next_mode = HMV_DOWN;
		end else if (qual.up) begin
			next_mode = HMV_UP;
		end else begin
			next_mode = HMV_IDLE;
		end
		next_step_cnt = '0;
		step = 1'b0;
		// Count restarts on a mode change, so a new press steps at once
		unique case (mode)
			HMV_DOWN, HMV_UP: begin
				step = (step_cnt == '0);
				if (next_mode == mode && step_cnt != STEP_LAST) begin
					next_step_cnt = step_cnt + SW'(1);
				end
			end
			HMV_IDLE, HMV_MUTE: begin
				next_step_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= HMV_IDLE;
			step_cnt <= '0;
		end else begin
			mode <= next_mode;
			step_cnt <= next_step_cnt;
		end
	end

	// APB decode
	logic hit_level;
	logic hit_status;
	logic setup;
	logic access;
	logic wr_level;
	logic bad_index;
	logic ro_write;

	assign hit_level = (paddr[11:2] == `HMV_IDX_LEVEL);
	assign hit_status = (paddr[11:2] == `HMV_IDX_STATUS);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_level = access && pwrite && hit_level;
	// Zero wait states: ready is the access phase itself
	assign pready = access;
	assign bad_index = !(hit_level || hit_status);
	assign ro_write = pwrite && hit_status;
	assign pslverr = access && (bad_index || ro_write);

	// Level register
	hmv_level_t level;
	hmv_level_t next_level;
	hmv_level_t wr_val;

	function automatic hmv_level_t wr_val_sel(input logic sel, input hmv_level_t a,
			input hmv_level_t b);
		return sel ? a : b;
	endfunction

	// A button change wins over a write in the same cycle
	always_comb begin
		wr_val = level;
		if (pstrb[0]) begin
			wr_val.l_attn = hmv_clamp(pwdata[4:0]);
			wr_val.l_mute = pwdata[7];
		end
		if (pstrb[1]) begin
			wr_val.r_attn = hmv_clamp(pwdata[12:8]);
			wr_val.r_mute = pwdata[15];
		end
		wr_val.l_rsv = 2'h0;
		wr_val.r_rsv = 2'h0;
		next_level = wr_val_sel(wr_level, wr_val, level);
		if (mode == HMV_MUTE) begin
			next_level.l_mute = 1'b1;
			next_level.r_mute = 1'b1;
		end else if (step) begin
			next_level.l_attn = hmv_step(level.l_attn, mode == HMV_UP);
			next_level.r_attn = hmv_step(level.r_attn, mode == HMV_UP);
			next_level.l_mute = 1'b0;
			next_level.r_mute = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= hmv_level_t'(`HMV_LEVEL_RESET);
		end else begin
			level <= next_level;
		end
	end

	// Read data and outputs
	logic [31:0] next_prdata;
	logic [15:0] status;

	// Read data is captured in setup so it stands through the access phase
	always_comb begin
		status = 16'h0000;
		status[`HMV_ST_DOWN_BIT] = qual.down;
		status[`HMV_ST_UP_BIT] = qual.up;
		status[`HMV_ST_MODE_MSB:`HMV_ST_MODE_LSB] = mode;
		next_prdata = prdata;
		if (setup) begin
			next_prdata = 32'h0000_0000;
			if (hit_level) begin
				next_prdata = {16'h0000, level};
			end else if (hit_status) begin
				next_prdata = {16'h0000, status};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			left_out_attn <= 5'h00;
			left_out_mute <= 1'b0;
			right_out_attn <= 5'h00;
			right_out_mute <= 1'b0;
		end else begin
			prdata <= next_prdata;
			left_out_attn <= level.l_attn;
			left_out_mute <= level.l_mute;
			right_out_attn <= level.r_attn;
			right_out_mute <= level.r_mute;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_down_lowers: assert property (mode == HMV_DOWN && step && level.l_attn < ATTN_MAX
		|=> level.l_attn == $past(level.l_attn) + 5'h01)
		else $error("down step did not add one code");
	chk_up_raises: assert property (mode == HMV_UP && step && level.r_attn != 5'h00
		|=> level.r_attn == $past(level.r_attn) - 5'h01)
		else $error("up step did not remove one code");
	chk_step_spacing: assert property (step && mode == HMV_DOWN ##1 mode == HMV_DOWN |-> !step)
		else $error("steps came too close together");
	chk_mute_both: assert property (qual.down && qual.up |=> ##1 level.l_mute && level.r_mute)
		else $error("both buttons did not mute");
	chk_read_mirror: assert property (setup && hit_level |=> prdata == {16'h0000, $past(level)})
		else $error("level read does not show current setting");
	chk_attn_range: assert property (level.l_attn <= ATTN_MAX && level.r_attn <= ATTN_MAX)
		else $error("attenuation code out of range");
	chk_out_follow: assert property (##1 left_out_attn == $past(level.l_attn)
		&& left_out_mute == $past(level.l_mute) && right_out_attn == $past(level.r_attn)
		&& right_out_mute == $past(level.r_mute))
		else $error("line outputs do not follow level");
	chk_saturate_max: assert property (level.l_attn == ATTN_MAX && mode == HMV_DOWN
		&& !wr_level |=> level.l_attn == ATTN_MAX)
		else $error("attenuation wrapped past maximum");
	chk_idle_holds: assert property (mode == HMV_IDLE && !wr_level |=> level == $past(level))
		else $error("level changed with no qualified button");
	chk_sw_write_lands: assert property (wr_level && mode == HMV_IDLE && pstrb[0]
		&& pwdata[4:0] <= ATTN_MAX |=> level.l_attn == $past(pwdata[4:0]))
		else $error("written attenuation did not land");
	chk_sw_clamps: assert property (wr_level && mode == HMV_IDLE && pstrb[1]
		&& pwdata[12:8] > ATTN_MAX |=> level.r_attn == ATTN_MAX)
		else $error("written attenuation not clamped");
	chk_step_unmutes: assert property (step |=> !level.l_mute && !level.r_mute)
		else $error("step left a channel muted");
	chk_status_mode: assert property (setup && hit_status
		|=> prdata[`HMV_ST_MODE_MSB:`HMV_ST_MODE_LSB] == $past(mode))
		else $error("status read does not show mode");

	cov_down_step: cover property (mode == HMV_DOWN && step);
	cov_up_step: cover property (mode == HMV_UP && step);
	cov_mute: cover property (mode == HMV_MUTE ##1 level.l_mute);
	cov_sw_write: cover property (wr_level);
	cov_sat_min: cover property (mode == HMV_UP && step && level.l_attn == 5'h00);

endmodule // hmv_top

`default_nettype wire

// *** testbench/hmv_button_model.sv ***
// Pushbutton pair wired to the volume pins
`timescale 1ns/10ps
`default_nettype none

module hmv_button_model (
	input wire logic hold_down,
	input wire logic hold_up,
	output logic volume_down_button_n,
	output logic volume_up_button_n
);
	// lows last as long as commanded
	// Released pins rest at the pull-up level
	assign volume_down_button_n = !hold_down;
	assign volume_up_button_n = !hold_up;
endmodule // hmv_button_model

`default_nettype wire

// *** testbench/hmv_top_tb.sv ***
// Self-checking bench for the volume button block
`timescale 1ns/10ps
`default_nettype none

module hmv_top_tb;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, hd, hu, dn_n, up_n, lm, rm, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [4:0] la, ra;
	int mismatches, checks, n;

	hmv_top #(.DEBOUNCE_CYCLES(8), .STEP_CYCLES(16)) uut (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.volume_down_button_n(dn_n), .volume_up_button_n(up_n), .left_out_attn(la),
		.left_out_mute(lm), .right_out_attn(ra), .right_out_mute(rm));
	hmv_button_model btn (.hold_down(hd), .hold_up(hu), .volume_down_button_n(dn_n),
		.volume_up_button_n(up_n));

	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task timeout(input string nm);
		mismatches++;
		$display("CHECK FAILED %s expected answer seen timeout", nm);
		tally_and_finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			timeout("pready");
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wait_attn(input logic [4:0] v, input int lim);
		n = 0;
		while (la !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			timeout("attenuation");
		end
	endtask

	task ramp(input logic up, input logic [4:0] a, input logic [4:0] b, input logic [4:0] e);
		hd <= !up;
		hu <= up;
		wait_attn(a, 100);
		wait_attn(b, 100);
		chk("step period", 16, n);
		chk("right attn", b, ra);
		wait_attn(e, 1000);
		repeat (40) @(posedge clk);
		chk("saturated attn", e, la);
		apb(0, 12'h0a4, 0);
		chk("level reg", {19'h0, e, 3'h0, e}, rd);
		hd <= 0;
		hu <= 0;
		repeat (20) @(posedge clk);
	endtask

	task t_short;
		hd <= 1;
		repeat (5) @(posedge clk);
		hd <= 0;
		repeat (40) @(posedge clk);
		chk("short press attn", 0, la);
	endtask

	task t_mute;
		apb(1, 12'h0a4, 32'h0000_0a0a);
		repeat (3) @(posedge clk);
		chk("written attn", 10, ra);
		hd <= 1;
		hu <= 1;
		n = 0;
		while (lm !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) begin
			timeout("mute");
		end
		chk("both mute", 2'b11, {lm, rm});
		chk("attn kept", 10, la);
		apb(0, 12'h0a4, 0);
		chk("muted reg", 32'h8a8a, rd);
		apb(0, 12'h0a8, 0);
		chk("status mute", 32'h0000_0023, rd);
		hd <= 0;
		hu <= 0;
		repeat (20) @(posedge clk);
	endtask

	task t_unmapped;
		apb(1, 12'h0a4, 32'h0000_1f1f);
		apb(0, 12'h0a4, 0);
		chk("clamped reg", 32'h1e1e, rd);
		pstrb <= 4'h1;
		apb(1, 12'h0a4, 32'h0000_0505);
		pstrb <= 4'hf;
		apb(0, 12'h0a4, 0);
		chk("lane0 only", 32'h1e05, rd);
		apb(1, 12'h0a8, 0);
		chk("status write err", 1, er);
		apb(0, 12'h0b0, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
	endtask

	initial begin
		{nrst, psel, penable, pwrite, hd, hu} = 0;
		paddr = 0;
		pwdata = 0;
		pstrb = 4'hf;
		mismatches = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		nrst <= 1;
		repeat (3) @(posedge clk);
		apb(0, 12'h0a4, 0);
		chk("reset level", 0, rd);
		t_short;
		ramp(0, 5'd1, 5'd2, 5'd30);
		ramp(1, 5'd29, 5'd28, 5'd0);
		t_mute;
		t_unmapped;
		tally_and_finish;
	end
endmodule // hmv_top_tb

`default_nettype wire
